// [logic/pcc_pkg.sv]
// constants, field layout and mode codes of the pulse counter channel
// assumes a 25 MHz core clock and an apb slave with byte addresses
package pcc_pkg;

  // ***************************************************
  // register offsets
  // ***************************************************
  localparam logic [7:0] PCC_OFF_CTRL = 8'h00;
  localparam logic [7:0] PCC_OFF_CMD = 8'h04;
  localparam logic [7:0] PCC_OFF_PRESET = 8'h08;
  localparam logic [7:0] PCC_OFF_UPPER = 8'h0c;
  localparam logic [7:0] PCC_OFF_LOWER = 8'h10;
  localparam logic [7:0] PCC_OFF_FILT = 8'h14;
  localparam logic [7:0] PCC_OFF_COUNT = 8'h18;
  localparam logic [7:0] PCC_OFF_STATUS = 8'h1c;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int PCC_CTRL_METHOD_LSB = 0;
  localparam int PCC_CTRL_MULT_BIT = 2;
  localparam int PCC_CTRL_OP_LSB = 4;
  localparam int PCC_CTRL_ZCOND_LSB = 8;
  localparam int PCC_CTRL_ENSEL_BIT = 10;
  localparam int PCC_CTRL_RING_BIT = 11;
  localparam int PCC_CTRL_REV_BIT = 12;
  localparam int PCC_CTRL_CAPUSE_LSB = 16;
  localparam int PCC_CMD_CEN_BIT = 0;
  localparam int PCC_CMD_RST_BIT = 1;
  localparam int PCC_CMD_PRE_BIT = 2;
  localparam int PCC_FILT_W = 16;

  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [31:0] PCC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PCC_PRESET_RST = 32'h0000_0000;
  localparam logic [31:0] PCC_UPPER_RST = 32'h7fff_ffff;
  localparam logic [31:0] PCC_LOWER_RST = 32'h8000_0000;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int PCC_CLK_PERIOD_NS = 40;
  localparam int PCC_FILT_TIME_NS = 2000;
  localparam logic [PCC_FILT_W-1:0] PCC_FILT_CYCLES =
    PCC_FILT_W'((PCC_FILT_TIME_NS + PCC_CLK_PERIOD_NS - 1) / PCC_CLK_PERIOD_NS);

  // ***************************************************
  // mode codes
  // ***************************************************
  typedef enum logic [1:0] {
    PCC_TWO_PHASE = 2'h0,
    PCC_INDIV = 2'h1,
    PCC_DIRDET = 2'h2
  } pcc_method_t;

  typedef enum logic [2:0] {
    PCC_OP_SIMPLE = 3'h0,
    PCC_OP_RESET = 3'h1,
    PCC_OP_PRESET = 3'h2,
    PCC_OP_ENABLE = 3'h3,
    PCC_OP_EN_RESET = 3'h4,
    PCC_OP_EN_PRESET = 3'h5
  } pcc_op_t;

  typedef enum logic [1:0] {
    PCC_Z_RISE = 2'h0,
    PCC_Z_FALL = 2'h1,
    PCC_Z_HIGH = 2'h2,
    PCC_Z_LOW = 2'h3
  } pcc_zcond_t;

endpackage

// [logic/pcc_filter.sv]
// input time-constant filter for one count input
// assumes the raw input is synchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module pcc_filter
  import pcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic raw,
  input wire logic [PCC_FILT_W-1:0] tc,
  output logic filt
);

  logic [PCC_FILT_W-1:0] cnt;

  // new level passes only after it stood for tc cycles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      filt <= 1'b0;
    end else if (raw == filt) begin
      cnt <= '0;
    end else if (cnt + 16'h0001 >= tc) begin // R14
      cnt <= '0;
      filt <= raw;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end

  property p_filt_follows;
    @(posedge core_clk) disable iff (!resetn)
      $changed(filt) |-> filt == $past(raw);
  endproperty
  a_filt_follows: assert property (p_filt_follows) // R14
    else $error("filtered input changed against raw level");

endmodule
`default_nettype wire

// [logic/pcc_counter.sv]
// one pulse counter channel with apb register access
// assumes count and control pins synchronous to core_clk, apb master on core_clk
// Operation
// R01: three count methods selectable: two-phase, individual, direction detection.
// R02: two-phase decodes quadrature, 2x or 4x, direction by phase order.
// R03: individual: A adds, B subtracts, 1x or 2x.
// R04: direction detection: A pulses counted, B level selects direction.
// R05: simple operation counts regardless of Z and control inputs.
// R06: reset operation clears count on chosen Z edge or level.
// R07: preset operation loads preset on chosen Z edge or level.
// R08: enable operation counts only while chosen control 0 or 1 active.
// R09: enable reset counts while enabled, clears when enable turns on.
// R10: enable preset counts while enabled, loads preset when enable turns on.
// R11: program reset and preset requests accepted any time.
// R12: control used for counting cannot also serve capture; refused.
// R13: simple, reset, preset operations need count enable request set.
// R14: A and B filtered by time constant, default 2.0us.
// R15: upper limit defaults 2147483647, lower limit -2147483648.
// R16: direction setting, reversed inverts add and subtract.
// R17: linear counter holds at upper or lower limit.
// R18: ring counter wraps between limits and continues.
// R19: 4x counts all A and B edges; 2x both A edges.
// R20: 1x counts rising edges; 2x counts both edges.
`timescale 1ns/100ps
`default_nettype none
module pcc_counter
  import pcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_a,
  input wire logic in_b,
  input wire logic in_z,
  input wire logic ctl0,
  input wire logic ctl1,
  output logic [31:0] count_value,
  output logic count_enabled
);

  // ***************************************************
  // functions
  // ***************************************************
  function automatic logic ctl_conflict(input logic [31:0] v);
    logic [1:0] used;
    used = 2'b00;
    if (v[PCC_CTRL_OP_LSB +: 3] >= PCC_OP_ENABLE) begin
      used = v[PCC_CTRL_ENSEL_BIT] ? 2'b10 : 2'b01;
    end
    return |(used & v[PCC_CTRL_CAPUSE_LSB +: 2]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= PCC_OFF_STATUS);
  endfunction

  function automatic logic signed [31:0] apply_step(
    input logic signed [31:0] cur, input logic up, input logic ring,
    input logic signed [31:0] hi, input logic signed [31:0] lo);
    logic signed [31:0] r;
    r = cur;
    if (up) begin
      if (cur >= hi) begin
        r = ring ? lo : hi;
      end else begin
        r = cur + 32'sh0000_0001;
      end
    end else begin
      if (cur <= lo) begin
        r = ring ? hi : lo;
      end else begin
        r = cur - 32'sh0000_0001;
      end
    end
    return r;
  endfunction

  // ***************************************************
  // registers
  // ***************************************************
  logic [31:0] ctrl;
  logic cen_req;
  logic signed [31:0] preset_val;
  logic signed [31:0] upper;
  logic signed [31:0] lower;
  logic [PCC_FILT_W-1:0] filt_tc;
  logic signed [31:0] count;
  logic fa, fb, fz, fa_d, fb_d, fz_d, en_d;

  pcc_method_t method;
  pcc_op_t op;
  pcc_zcond_t zcond;
  logic mult, ring, rev, ensel;
  assign method = pcc_method_t'(ctrl[PCC_CTRL_METHOD_LSB +: 2]);
  assign op = pcc_op_t'(ctrl[PCC_CTRL_OP_LSB +: 3]);
  assign zcond = pcc_zcond_t'(ctrl[PCC_CTRL_ZCOND_LSB +: 2]);
  assign mult = ctrl[PCC_CTRL_MULT_BIT];
  assign ring = ctrl[PCC_CTRL_RING_BIT];
  assign rev = ctrl[PCC_CTRL_REV_BIT];
  assign ensel = ctrl[PCC_CTRL_ENSEL_BIT];

  // ***************************************************
  // apb slave
  // ***************************************************
  logic acc, wr, bad, ctrl_refused, cmd_rst, cmd_pre;
  assign acc = psel && penable;
  assign ctrl_refused = (paddr == PCC_OFF_CTRL) && ctl_conflict(pwdata);
  assign bad = !mapped(paddr) || (pwrite && ctrl_refused);
  assign wr = acc && pwrite && !bad;
  assign pready = 1'b1;
  assign pslverr = acc && bad;
  assign cmd_rst = wr && (paddr == PCC_OFF_CMD) && pwdata[PCC_CMD_RST_BIT];
  assign cmd_pre = wr && (paddr == PCC_OFF_CMD) && pwdata[PCC_CMD_PRE_BIT];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= PCC_CTRL_RST;
      cen_req <= 1'b0;
      preset_val <= PCC_PRESET_RST;
      upper <= PCC_UPPER_RST; // R15
      lower <= PCC_LOWER_RST; // R15
      filt_tc <= PCC_FILT_CYCLES; // R14
    end else if (wr) begin
      unique case (paddr)
        PCC_OFF_CTRL: ctrl <= pwdata; // R12
        PCC_OFF_CMD: cen_req <= pwdata[PCC_CMD_CEN_BIT];
        PCC_OFF_PRESET: preset_val <= pwdata;
        PCC_OFF_UPPER: upper <= pwdata;
        PCC_OFF_LOWER: lower <= pwdata;
        PCC_OFF_FILT: filt_tc <= pwdata[PCC_FILT_W-1:0];
        default: ;
      endcase
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        PCC_OFF_CTRL: prdata <= ctrl;
        PCC_OFF_CMD: prdata <= {31'h0000_0000, cen_req};
        PCC_OFF_PRESET: prdata <= preset_val;
        PCC_OFF_UPPER: prdata <= upper;
        PCC_OFF_LOWER: prdata <= lower;
        PCC_OFF_FILT: prdata <= {16'h0000, filt_tc};
        PCC_OFF_COUNT: prdata <= count;
        PCC_OFF_STATUS: prdata <= {28'h000_0000, count_enabled, fz, fb, fa};
        default: prdata <= '0;
      endcase
    end
  end

  // ***************************************************
  // input filters and edge history
  // ***************************************************
  pcc_filter u_filt_a (.core_clk(core_clk), .resetn(resetn), .raw(in_a), .tc(filt_tc),
    .filt(fa));
  pcc_filter u_filt_b (.core_clk(core_clk), .resetn(resetn), .raw(in_b), .tc(filt_tc),
    .filt(fb));
  pcc_filter u_filt_z (.core_clk(core_clk), .resetn(resetn), .raw(in_z), .tc(filt_tc),
    .filt(fz));

  logic en_sig;
  assign en_sig = ensel ? ctl1 : ctl0;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fa_d <= 1'b0;
      fb_d <= 1'b0;
      fz_d <= 1'b0;
      en_d <= 1'b0;
    end else begin
      fa_d <= fa;
      fb_d <= fb;
      fz_d <= fz;
      en_d <= en_sig;
    end
  end

  // ***************************************************
  // decode of count pulses
  // ***************************************************
  logic a_chg, b_chg, a_rise, b_rise, raw_up, raw_dn, step_up, step_dn;
  assign a_chg = fa ^ fa_d;
  assign b_chg = fb ^ fb_d;
  assign a_rise = fa && !fa_d;
  assign b_rise = fb && !fb_d;

  always_comb begin
    raw_up = 1'b0;
    raw_dn = 1'b0;
    unique case (method) // R01
      PCC_TWO_PHASE: begin
        // simultaneous A and B change is a phase error and ignored
        if ((a_chg && !b_chg) || (mult && b_chg && !a_chg)) begin // R19
          raw_up = fa ^ fb_d; // R02
          raw_dn = !(fa ^ fb_d);
        end
      end
      PCC_INDIV: begin
        raw_up = mult ? a_chg : a_rise; // R03 R20
        raw_dn = mult ? b_chg : b_rise;
      end
      PCC_DIRDET: begin
        if (mult ? a_chg : a_rise) begin // R04 R20
          raw_up = !fb;
          raw_dn = fb;
        end
      end
      default: ;
    endcase
  end

  // add and subtract at once cancel
  assign step_up = (rev ? raw_dn : raw_up) && !(raw_up && raw_dn); // R16
  assign step_dn = (rev ? raw_up : raw_dn) && !(raw_up && raw_dn); // R16

  // ***************************************************
  // count operation
  // ***************************************************
  logic z_evt, en_rise, clear, load;
  assign en_rise = en_sig && !en_d;

  always_comb begin
    unique case (zcond)
      PCC_Z_RISE: z_evt = fz && !fz_d;
      PCC_Z_FALL: z_evt = !fz && fz_d;
      PCC_Z_HIGH: z_evt = fz;
      PCC_Z_LOW: z_evt = !fz;
    endcase
  end

  assign count_enabled = (op >= PCC_OP_ENABLE) ? en_sig : cen_req; // R05 R08 R13
  assign clear = cmd_rst || (op == PCC_OP_RESET && z_evt) // R11 R06
    || (op == PCC_OP_EN_RESET && en_rise); // R09
  assign load = cmd_pre || (op == PCC_OP_PRESET && z_evt) // R11 R07
    || (op == PCC_OP_EN_PRESET && en_rise); // R10

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (load) begin
      count <= preset_val;
    end else if (count_enabled && (step_up || step_dn)) begin
      count <= apply_step(count, step_up, ring, upper, lower); // R17 R18
    end
  end

  assign count_value = count;

  // ***************************************************
  // assertions
  // ***************************************************
  sequence s_cmd_write(int bitpos);
    psel && penable && pwrite && paddr == PCC_OFF_CMD && pwdata[bitpos];
  endsequence

  property p_prog_reset;
    @(posedge core_clk) disable iff (!resetn)
      s_cmd_write(PCC_CMD_RST_BIT) |=> count == 0;
  endproperty
  a_prog_reset: assert property (p_prog_reset) // R11
    else $error("program reset did not clear count");

  property p_prog_preset;
    @(posedge core_clk) disable iff (!resetn)
      s_cmd_write(PCC_CMD_PRE_BIT) and !clear |=> count == $past(preset_val);
  endproperty
  a_prog_preset: assert property (p_prog_preset) // R11
    else $error("program preset did not load preset");

  property p_linear_hold;
    @(posedge core_clk) disable iff (!resetn)
      !ring && count == upper && count_enabled && step_up && !clear && !load
      |=> count == $past(upper);
  endproperty
  a_linear_hold: assert property (p_linear_hold) // R17
    else $error("linear counter did not hold upper limit");

  property p_ring_wrap;
    @(posedge core_clk) disable iff (!resetn)
      ring && count == lower && count_enabled && step_dn && !clear && !load
      |=> count == $past(upper);
  endproperty
  a_ring_wrap: assert property (p_ring_wrap) // R18
    else $error("ring counter did not wrap to upper limit");

  property p_no_count_idle;
    @(posedge core_clk) disable iff (!resetn)
      !count_enabled && !clear && !load |=> $stable(count);
  endproperty
  a_no_count_idle: assert property (p_no_count_idle) // R13
    else $error("count moved while counting disabled");

  property p_z_reset;
    @(posedge core_clk) disable iff (!resetn)
      op == PCC_OP_RESET && zcond == PCC_Z_RISE && fz && !fz_d |=> count == 0;
  endproperty
  a_z_reset: assert property (p_z_reset) // R06
    else $error("z rising edge did not clear count");

  property p_enable_reset;
    @(posedge core_clk) disable iff (!resetn)
      op == PCC_OP_EN_RESET && $rose(en_sig) |=> count == 0;
  endproperty
  a_enable_reset: assert property (p_enable_reset) // R09
    else $error("enable edge did not clear count");

  property p_conflict_refused;
    @(posedge core_clk) disable iff (!resetn)
      acc && pwrite && paddr == PCC_OFF_CTRL && ctl_conflict(pwdata)
      |-> pslverr ##1 $stable(ctrl);
  endproperty
  a_conflict_refused: assert property (p_conflict_refused) // R12
    else $error("conflicting control assignment was taken");

  property p_quad_up;
    @(posedge core_clk) disable iff (!resetn)
      method == PCC_TWO_PHASE && !rev && count_enabled && !clear && !load
      && fa_d == 1'b0 && fb_d == 1'b0 && fa && !fb && count < upper
      |=> count == $past(count) + 1;
  endproperty
  a_quad_up: assert property (p_quad_up) // R02
    else $error("quadrature A-leading edge did not add one");

endmodule
`default_nettype wire

// [test/pcc_encoder.sv]
// encoder model driving the count and z inputs of the channel
// assumes the channel samples its inputs on rising clk
`timescale 1ns/100ps
`default_nettype none
module pcc_encoder #(
  parameter int HOLD = 8
) (
  input wire logic clk,
  output logic a,
  output logic b,
  output logic z
);
  logic [1:0] ph;
  initial begin
    a = 1'b0;
    b = 1'b0;
    z = 1'b0;
    ph = 2'd0;
  end
  // each level outlasts the input filter
  task automatic hold();
    repeat (HOLD) @(posedge clk);
  endtask
  // a leads b going up: 00,10,11,01
  task automatic quad(input logic up);
    ph = up ? ph + 2'd1 : ph - 2'd1;
    a <= ph[1] ^ ph[0];
    b <= ph[1];
    hold();
  endtask
  task automatic pulse(input logic on_b);
    if (on_b) b <= 1'b1;
    else a <= 1'b1;
    hold();
    if (on_b) b <= 1'b0;
    else a <= 1'b0;
    hold();
  endtask
  task automatic set_b(input logic v);
    b <= v;
    hold();
  endtask
  task automatic set_z(input logic v);
    z <= v;
    hold();
  endtask
endmodule
`default_nettype wire

// [test/pulse_counter_channel_modes_tb.sv]
// self-checking bench for the pulse counter channel
// assumes pcc_counter with apb access and the encoder model
`timescale 1ns/100ps
`default_nettype none
module pulse_counter_channel_modes_tb import pcc_pkg::*; ();
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, er, idle;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, cur_ctrl, count_value;
  logic in_a, in_b, in_z, ctl0, ctl1, count_enabled;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int zc;

  always #20 core_clk = ~core_clk;

  pcc_counter uut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_a(in_a), .in_b(in_b), .in_z(in_z), .ctl0(ctl0), .ctl1(ctl1),
    .count_value(count_value), .count_enabled(count_enabled));
  pcc_encoder enc (.clk(core_clk), .a(in_a), .b(in_b), .z(in_z));

  // ***************************************************
  // tasks
  // ***************************************************
  task automatic check(input string n, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", n, exp, got);
      bad_count++;
    end
  endtask
  task automatic cc(input logic [31:0] exp);
    check("count", exp, count_value);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // the wait ends on the first edge that sees pready high
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(n, exp, rd);
  endtask
  function automatic logic [31:0] mk(input logic [1:0] m, input logic mu, input logic [2:0] op,
    input logic [1:0] z, input logic es, input logic rg, input logic rv);
    mk = 32'(m) | (32'(mu) << PCC_CTRL_MULT_BIT) | (32'(op) << PCC_CTRL_OP_LSB);
    mk = mk | (32'(z) << PCC_CTRL_ZCOND_LSB) | (32'(es) << PCC_CTRL_ENSEL_BIT);
    mk = mk | (32'(rg) << PCC_CTRL_RING_BIT) | (32'(rv) << PCC_CTRL_REV_BIT);
  endfunction
  task automatic ctrl(input logic [1:0] m, input logic mu, input logic [2:0] op,
    input logic [1:0] z, input logic es, input logic rg, input logic rv);
    cur_ctrl = mk(m, mu, op, z, es, rg, rv);
    apb(1'b1, PCC_OFF_CTRL, cur_ctrl);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ***************************************************
  // tests
  // ***************************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ctl0 = 1'b0;
    ctl1 = 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rdc("upper", PCC_OFF_UPPER, 32'h7fff_ffff);
    rdc("lower", PCC_OFF_LOWER, 32'h8000_0000);
    rdc("filt", PCC_OFF_FILT, 32'h0000_0032);
    rdc("ctrl", PCC_OFF_CTRL, 32'h0000_0000);
    apb(1'b1, PCC_OFF_FILT, 32'h0000_0002);
    repeat (4) enc.quad(1'b1);
    cc(32'h0000_0000);
    check("enabled", 32'h0000_0000, {31'h0, count_enabled});
    apb(1'b1, PCC_OFF_CMD, 32'h0000_0001);
    check("enabled", 32'h0000_0001, {31'h0, count_enabled});
    $display("test defaults done");
    repeat (4) enc.quad(1'b1);
    cc(32'h0000_0002);
    ctrl(2'd0, 1'b1, 3'd0, 2'd0, 1'b0, 1'b0, 1'b0);
    repeat (4) enc.quad(1'b1);
    cc(32'h0000_0006);
    repeat (4) enc.quad(1'b0);
    cc(32'h0000_0002);
    apb(1'b1, PCC_OFF_CMD, 32'h0000_0003);
    cc(32'h0000_0000);
    apb(1'b1, PCC_OFF_PRESET, 32'h0000_0005);
    apb(1'b1, PCC_OFF_CMD, 32'h0000_0005);
    cc(32'h0000_0005);
    $display("test two phase done");
    enc.set_z(1'b1);
    ctl0 <= 1'b1;
    ctrl(2'd1, 1'b0, 3'd0, 2'd0, 1'b0, 1'b0, 1'b0);
    repeat (2) enc.pulse(1'b0);
    cc(32'h0000_0007);
    enc.pulse(1'b1);
    cc(32'h0000_0006);
    ctrl(2'd1, 1'b1, 3'd0, 2'd0, 1'b0, 1'b0, 1'b0);
    enc.pulse(1'b0);
    cc(32'h0000_0008);
    enc.set_z(1'b0);
    ctl0 <= 1'b0;
    ctrl(2'd2, 1'b0, 3'd0, 2'd0, 1'b0, 1'b0, 1'b0);
    enc.pulse(1'b0);
    cc(32'h0000_0009);
    enc.set_b(1'b1);
    enc.pulse(1'b0);
    cc(32'h0000_0008);
    ctrl(2'd2, 1'b0, 3'd0, 2'd0, 1'b0, 1'b0, 1'b1);
    enc.pulse(1'b0);
    cc(32'h0000_0009);
    enc.set_b(1'b0);
    ctrl(2'd2, 1'b1, 3'd0, 2'd0, 1'b0, 1'b0, 1'b0);
    enc.pulse(1'b0);
    cc(32'h0000_000b);
    $display("test methods done");
    apb(1'b1, PCC_OFF_CMD, 32'h0000_0003);
    apb(1'b1, PCC_OFF_UPPER, 32'h0000_0001);
    ctrl(2'd2, 1'b0, 3'd0, 2'd0, 1'b0, 1'b0, 1'b0);
    repeat (2) enc.pulse(1'b0);
    cc(32'h0000_0001);
    apb(1'b1, PCC_OFF_LOWER, 32'hffff_fffe);
    ctrl(2'd2, 1'b0, 3'd0, 2'd0, 1'b0, 1'b1, 1'b0);
    enc.pulse(1'b0);
    cc(32'hffff_fffe);
    enc.set_b(1'b1);
    enc.pulse(1'b0);
    cc(32'h0000_0001);
    enc.set_b(1'b0);
    apb(1'b1, PCC_OFF_UPPER, 32'h7fff_ffff);
    apb(1'b1, PCC_OFF_LOWER, 32'h8000_0000);
    apb(1'b1, PCC_OFF_CMD, 32'h0000_0003);
    $display("test limits done");
    for (zc = 0; zc < 4; zc++) begin
      idle = (zc == 1 || zc == 3);
      ctrl(2'd2, 1'b0, 3'd1, 2'(zc), 1'b0, 1'b0, 1'b0);
      enc.set_z(idle);
      enc.pulse(1'b0);
      cc(32'h0000_0001);
      enc.set_z(!idle);
      cc(32'h0000_0000);
    end
    ctrl(2'd2, 1'b0, 3'd2, 2'd0, 1'b0, 1'b0, 1'b0);
    enc.pulse(1'b0);
    enc.set_z(1'b1);
    cc(32'h0000_0005);
    enc.set_z(1'b0);
    $display("test z ops done");
    ctrl(2'd2, 1'b0, 3'd3, 2'd0, 1'b1, 1'b0, 1'b0);
    check("enabled", 32'h0000_0000, {31'h0, count_enabled});
    enc.pulse(1'b0);
    cc(32'h0000_0005);
    ctl1 <= 1'b1;
    repeat (2) @(posedge core_clk);
    enc.pulse(1'b0);
    cc(32'h0000_0006);
    ctrl(2'd2, 1'b0, 3'd4, 2'd0, 1'b0, 1'b0, 1'b0);
    enc.pulse(1'b0);
    cc(32'h0000_0006);
    ctl0 <= 1'b1;
    repeat (4) @(posedge core_clk);
    cc(32'h0000_0000);
    enc.pulse(1'b0);
    cc(32'h0000_0001);
    ctl0 <= 1'b0;
    ctrl(2'd2, 1'b0, 3'd5, 2'd0, 1'b0, 1'b0, 1'b0);
    ctl0 <= 1'b1;
    repeat (4) @(posedge core_clk);
    cc(32'h0000_0005);
    $display("test enable ops done");
    apb(1'b1, PCC_OFF_CTRL, mk(2'd2, 1'b0, 3'd3, 2'd0, 1'b0, 1'b0, 1'b0) | 32'h0001_0000);
    check("ctrl error", 32'h0000_0001, {31'h0, er});
    rdc("ctrl", PCC_OFF_CTRL, cur_ctrl);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped error", 32'h0000_0001, {31'h0, er});
    check("unmapped data", 32'h0000_0000, rd);
    rdc("count reg", PCC_OFF_COUNT, 32'h0000_0005);
    rdc("status", PCC_OFF_STATUS, 32'h0000_0008);
    $display("test refusals done");
    report_and_stop();
  end
endmodule
`default_nettype wire
